// >>> deh_cfg.svh
/*
  Constants of the error-history register bank: object indices, sub-indices,
  field positions, error-field codes and list geometry.
  Assumes it is included by its bare name before the package and the modules.
*/
`ifndef DEH_CFG_SVH
`define DEH_CFG_SVH

// Object indices
`define DEH_IDX_DEVICE_TYPE   16'h1000
`define DEH_IDX_ERROR_FLAGS   16'h1001
`define DEH_IDX_VENDOR_STATUS 16'h1002
`define DEH_IDX_HISTORY       16'h1003

// Sub-indices
`define DEH_SUB_ZERO          8'h00
`define DEH_SUB_LAST_ENTRY    8'h04

// List geometry
`define DEH_LIST_DEPTH        4
`define DEH_CNT_W             3
`define DEH_CNT_FULL          3'h4
`define DEH_CNT_ONE           3'h1
`define DEH_SRC_W             4
`define DEH_NSRC              9

// Error register layout
`define DEH_GENERIC_BIT       0
`define DEH_FLAGS_RESET       8'h00

// Function-block class bits of the device-type upper half
`define DEH_FB_DIG_IN         16'h0001
`define DEH_FB_ANA_IN         16'h0002
`define DEH_FB_DIG_OUT        16'h0004
`define DEH_FB_ANA_OUT        16'h0008
`define DEH_FB_CONTROLLER     16'h0010
`define DEH_FB_ALARM          16'h0020
`define DEH_FB_LOOKUP         16'h2000
`define DEH_FB_PROG_LOGIC     16'h4000
`define DEH_FB_MISC           16'h8000

// Emergency codes
`define DEH_EC_INPUT_OVL      16'hF001
`define DEH_EC_OUTPUT_OVL     16'hF002
`define DEH_EC_OUTPUT_SHORT   16'h2310
`define DEH_EC_COMM_GENERIC   16'h8100
`define DEH_EC_GUARD          16'h8130

// Error descriptions
`define DEH_DS_OVER_HIGH      8'h20
`define DEH_DS_OVER_LOW       8'h40
`define DEH_DS_OPEN           8'h10
`define DEH_DS_SHORT          8'h00
`define DEH_DS_NONE           8'h00
`define DEH_DS_LIFEGUARD      8'h10
`define DEH_DS_HEARTBEAT      8'h80

// Channel numbers
`define DEH_CH_NONE           8'h00
`define DEH_CH_1              8'h01
`define DEH_CH_2              8'h02

// Error-reset indication, also what an empty slot reads
`define DEH_CODE_RESET        32'h00000000

`endif

// >>> deh_pkg.sv
/*
  Types of the error-history register bank.
  Assumes deh_cfg.svh is on the include path.
*/
`default_nettype none
`include "deh_cfg.svh"

package deh_pkg;

  // Fault sources, in the order of the fault_level vector
  typedef enum logic [`DEH_SRC_W-1:0] {
    DEH_SRC_IN1_HIGH  = 4'h0,
    DEH_SRC_IN1_LOW   = 4'h1,
    DEH_SRC_OUT1_OPEN = 4'h2,
    DEH_SRC_OUT2_OPEN = 4'h3,
    DEH_SRC_OUT1_SHRT = 4'h4,
    DEH_SRC_OUT2_SHRT = 4'h5,
    DEH_SRC_RPDO_TMO  = 4'h6,
    DEH_SRC_LIFEGUARD = 4'h7,
    DEH_SRC_HEARTBEAT = 4'h8
  } deh_src_t;

  typedef struct packed {
    logic [31:0]           code;
    logic [`DEH_SRC_W-1:0] src;
  } deh_entry_t;

  typedef struct packed {
    deh_entry_t [`DEH_LIST_DEPTH-1:0] list;
    logic [`DEH_CNT_W-1:0]            cnt;
    logic                             generic;
    logic [31:0]                      rdata;
    logic                             ack;
    logic                             abort;
  } deh_state_t;

endpackage : deh_pkg

`default_nettype wire

// >>> deh_evt_if.sv
/*
  Carrier for fault edges between the fault monitor and the list logic.
  Assumes both ends share one clock; all signals are valid in one cycle.
*/
`default_nettype none

interface deh_evt_if #(
  parameter int NSRC = 9
);
  logic [NSRC-1:0] rise;
  logic [NSRC-1:0] fall;
  logic [NSRC-1:0] active;

  modport mon (output rise, output fall, output active);
  modport lst (input rise, input fall, input active);
endinterface : deh_evt_if

`default_nettype wire

// >>> deh_fault_mon.sv
/*
  Fault monitor: turns fault levels into onset and clear pulses.
  Assumes fault levels are synchronous to clk_sys.
*/
`default_nettype none

module deh_fault_mon #(
  parameter int NSRC = 9
) (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            ce,
  input  wire logic [NSRC-1:0] fault_level,
  deh_evt_if.mon               evt
);

  typedef struct packed {
    logic [NSRC-1:0] prev;
  } deh_mon_state_t;

  deh_mon_state_t st_ff;
  deh_mon_state_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = fault_level;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // Pulses are gated by ce so a frozen block sees no phantom edges
  assign evt.rise   = ce ? (fault_level & ~st_ff.prev) : '0;
  assign evt.fall   = ce ? (~fault_level & st_ff.prev) : '0;
  assign evt.active = fault_level;

endmodule : deh_fault_mon

`default_nettype wire

// >>> deh_error_bank.sv
/*
  Error-reporting part of the node's object dictionary: device-type word,
  generic error register, vendor status word and a four-entry error history.
  Assumes a protocol engine outside presents decoded dictionary accesses as
  one-cycle strobes with index, sub-index and write data, synchronous to
  clk_sys, and fault detectors that drive steady levels.
*/
`default_nettype none
`include "deh_cfg.svh"

module deh_error_bank
  import deh_pkg::*;
#(
  parameter logic [15:0] PROFILE_NUMBER = 16'h0001,  // Arbitrary value
  parameter logic [15:0] FB_CLASSES     = `DEH_FB_ANA_IN | `DEH_FB_ANA_OUT,  // Arbitrary value
  parameter int          NSRC           = `DEH_NSRC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Fault levels from the detectors
  input  wire logic        in1_over_high,
  input  wire logic        in1_over_low,
  input  wire logic [1:0]  out_open,
  input  wire logic [1:0]  out_short,
  input  wire logic        rpdo_timeout,
  input  wire logic        lifeguard_event,
  input  wire logic        hb_timeout,
  input  wire logic [7:0]  hb_node_id,
  // Dictionary access
  input  wire logic        od_rd,
  input  wire logic        od_wr,
  input  wire logic [15:0] od_index,
  input  wire logic [7:0]  od_subindex,
  input  wire logic [31:0] od_wdata,
  output logic      [31:0] od_rdata_ff,
  output logic             od_ack_ff,
  output logic             od_abort_ff,
  output logic             generic_error_ff
);

  deh_state_t      st_ff;
  deh_state_t      nxt_st;
  logic [NSRC-1:0] fault_level;

  deh_evt_if #(.NSRC(NSRC)) evt ();

  assign fault_level[DEH_SRC_IN1_HIGH]  = in1_over_high;
  assign fault_level[DEH_SRC_IN1_LOW]   = in1_over_low;
  assign fault_level[DEH_SRC_OUT1_OPEN] = out_open[0];
  assign fault_level[DEH_SRC_OUT2_OPEN] = out_open[1];
  assign fault_level[DEH_SRC_OUT1_SHRT] = out_short[0];
  assign fault_level[DEH_SRC_OUT2_SHRT] = out_short[1];
  assign fault_level[DEH_SRC_RPDO_TMO]  = rpdo_timeout;
  assign fault_level[DEH_SRC_LIFEGUARD] = lifeguard_event;
  assign fault_level[DEH_SRC_HEARTBEAT] = hb_timeout;

  deh_fault_mon #(
    .NSRC        (NSRC)
  ) u_mon (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .ce          (ce),
    .fault_level (fault_level),
    .evt         (evt)
  );

  // Error-field code for a source: description, channel, emergency code
  function automatic logic [31:0] deh_code(
    input logic [`DEH_SRC_W-1:0] src,
    input logic [7:0]            node
  );
    logic [31:0] c;
    c = `DEH_CODE_RESET;
    case (src)
      DEH_SRC_IN1_HIGH: begin
        c = {`DEH_DS_OVER_HIGH, `DEH_CH_1, `DEH_EC_INPUT_OVL};
      end
      DEH_SRC_IN1_LOW: begin
        c = {`DEH_DS_OVER_LOW, `DEH_CH_1, `DEH_EC_INPUT_OVL};
      end
      DEH_SRC_OUT1_OPEN: begin
        c = {`DEH_DS_OPEN, `DEH_CH_1, `DEH_EC_OUTPUT_OVL};
      end
      DEH_SRC_OUT2_OPEN: begin
        c = {`DEH_DS_OPEN, `DEH_CH_2, `DEH_EC_OUTPUT_OVL};
      end
      DEH_SRC_OUT1_SHRT: begin
        c = {`DEH_DS_SHORT, `DEH_CH_1, `DEH_EC_OUTPUT_SHORT};
      end
      DEH_SRC_OUT2_SHRT: begin
        c = {`DEH_DS_SHORT, `DEH_CH_2, `DEH_EC_OUTPUT_SHORT};
      end
      DEH_SRC_RPDO_TMO: begin
        c = {`DEH_DS_NONE, `DEH_CH_NONE, `DEH_EC_COMM_GENERIC};
      end
      DEH_SRC_LIFEGUARD: begin
        c = {`DEH_DS_LIFEGUARD, `DEH_CH_NONE, `DEH_EC_GUARD};
      end
      DEH_SRC_HEARTBEAT: begin
        c = {`DEH_DS_HEARTBEAT, node, `DEH_EC_GUARD};
      end
      default: begin
        c = `DEH_CODE_RESET;
      end
    endcase
    return c;
  endfunction : deh_code

  logic                             acc;
  logic                             hit_hist;
  logic                             sub_zero;
  logic                             sub_entry;
  logic                             do_clear;
  logic [31:0]                      rd_val;
  logic                             rd_bad;
  deh_entry_t [`DEH_LIST_DEPTH-1:0] lst;
  deh_entry_t [`DEH_LIST_DEPTH-1:0] tmp;
  logic [`DEH_CNT_W-1:0]            cnt;
  logic [`DEH_CNT_W-1:0]            j;
  logic [`DEH_SRC_W-1:0]            s4;

  assign acc       = ce & (od_rd | od_wr);
  assign hit_hist  = (od_index == `DEH_IDX_HISTORY);
  assign sub_zero  = (od_subindex == `DEH_SUB_ZERO);
  assign sub_entry = !sub_zero && (od_subindex <= `DEH_SUB_LAST_ENTRY);

  // Read mux; entries past the count read as the reset code
  always_comb begin
    rd_val = `DEH_CODE_RESET;
    rd_bad = 1'b0;
    if (od_index == `DEH_IDX_DEVICE_TYPE) begin
      rd_val = {FB_CLASSES, PROFILE_NUMBER};
      rd_bad = !sub_zero;
    end else if (od_index == `DEH_IDX_ERROR_FLAGS) begin
      rd_val = {24'h000000, `DEH_FLAGS_RESET};
      rd_val[`DEH_GENERIC_BIT] = st_ff.generic;
      rd_bad = !sub_zero;
    end else if (od_index == `DEH_IDX_VENDOR_STATUS) begin
      // Debug view: live fault levels and list fill
      rd_val = {16'h0000, 4'h0, st_ff.cnt[`DEH_CNT_W-1:0], NSRC'(fault_level)};
      rd_bad = !sub_zero;
    end else if (hit_hist && sub_zero) begin
      rd_val = {29'h00000000, st_ff.cnt};
    end else if (hit_hist && sub_entry) begin
      if (od_subindex[`DEH_CNT_W-1:0] <= st_ff.cnt) begin
        rd_val = st_ff.list[od_subindex[1:0] - 2'h1].code;
      end else begin
        rd_val = `DEH_CODE_RESET;
      end
    end else begin
      rd_bad = 1'b1;
    end
  end

  // Only a zero written to the count is accepted; everything else aborts
  assign do_clear = acc && od_wr && hit_hist && sub_zero
                    && (od_wdata == 32'h00000000);

  always_comb begin
    nxt_st = st_ff;
    lst    = st_ff.list;
    cnt    = st_ff.cnt;
    tmp    = '0;
    j      = '0;
    s4     = '0;
    nxt_st.ack   = 1'b0;
    nxt_st.abort = 1'b0;

    if (acc) begin
      nxt_st.ack = 1'b1;
      if (od_rd) begin
        nxt_st.rdata = rd_val;
        nxt_st.abort = rd_bad;
      end else begin
        // Entries and fixed words are read-only
        nxt_st.abort = !do_clear;
      end
    end

    // Clear first, so an onset in the same cycle still lands in the list
    if (do_clear) begin
      lst = '0;
      cnt = '0;
    end

    // Removal with compaction, one pass per cleared source
    for (int s = 0; s < NSRC; s++) begin
      if (evt.fall[s]) begin
        s4  = s[`DEH_SRC_W-1:0];
        tmp = '0;
        j   = '0;
        for (int i = 0; i < `DEH_LIST_DEPTH; i++) begin
          if ((i < int'(cnt)) && (lst[i].src != s4)) begin
            tmp[j[1:0]] = lst[i];
            j = j + `DEH_CNT_ONE;
          end
        end
        lst = tmp;
        cnt = j;
      end
    end

    // Insertion at the top; the bottom entry falls off a full list
    for (int s = 0; s < NSRC; s++) begin
      if (evt.rise[s]) begin
        s4 = s[`DEH_SRC_W-1:0];
        for (int i = `DEH_LIST_DEPTH - 1; i > 0; i--) begin
          lst[i] = lst[i-1];
        end
        lst[0].code = deh_code(s4, hb_node_id);
        lst[0].src  = s4;
        if (cnt < `DEH_CNT_FULL) begin
          cnt = cnt + `DEH_CNT_ONE;
        end
      end
    end

    nxt_st.list = lst;
    nxt_st.cnt  = cnt;
    // Follows live faults, so clearing the list cannot hide one
    nxt_st.generic = |evt.active;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign od_rdata_ff      = st_ff.rdata;
  assign od_ack_ff        = st_ff.ack;
  assign od_abort_ff      = st_ff.abort;
  assign generic_error_ff = st_ff.generic;

endmodule : deh_error_bank

`default_nettype wire

// >>> deh_error_bank_chk.sv
/*
  Port checker for the error-history register bank.
  Assumes it is bound to deh_error_bank with its default parameters.
*/
`default_nettype none

module deh_error_bank_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        in1_over_high,
  input wire logic        in1_over_low,
  input wire logic [1:0]  out_open,
  input wire logic [1:0]  out_short,
  input wire logic        rpdo_timeout,
  input wire logic        lifeguard_event,
  input wire logic        hb_timeout,
  input wire logic        od_rd,
  input wire logic        od_wr,
  input wire logic [15:0] od_index,
  input wire logic [7:0]  od_subindex,
  input wire logic [31:0] od_rdata_ff,
  input wire logic        od_ack_ff,
  input wire logic        od_abort_ff,
  input wire logic        generic_error_ff
);
  timeunit 1ns;
  timeprecision 1ps;

  wire logic req     = ce && (od_rd || od_wr);
  wire logic rd_sub0 = ce && od_rd && od_subindex == 8'h00;
  wire logic any_flt = in1_over_high | in1_over_low | (|out_open) | (|out_short)
                       | rpdo_timeout | lifeguard_event | hb_timeout;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_ACK_NEXT: assert property (req |=> od_ack_ff)
    else $error("access not answered");
  AST_ACK_IDLE: assert property (ce && !od_rd && !od_wr |=> !od_ack_ff)
    else $error("answer without access");
  AST_ABORT_ACK: assert property (od_abort_ff |-> od_ack_ff)
    else $error("refusal without answer");
  AST_BAD_INDEX: assert property (req && od_index[15:2] != 14'h0400 |=> od_abort_ff)
    else $error("unmapped index accepted");
  AST_LIST_RO: assert property (
    ce && od_wr && od_index == 16'h1003 && od_subindex != 8'h00 |=> od_abort_ff)
    else $error("history entry written");
  AST_TYPE_WORD: assert property (
    rd_sub0 && od_index == 16'h1000 |=> !od_abort_ff && od_rdata_ff == 32'h000A0001)
    else $error("device type word wrong");
  AST_FLAGS_ZERO: assert property (
    rd_sub0 && od_index == 16'h1001 |=> od_rdata_ff[31:1] == 31'h0)
    else $error("unused error bits set");
  AST_COUNT_MAX: assert property (
    rd_sub0 && od_index == 16'h1003 |=> od_rdata_ff <= 32'h4)
    else $error("entry count above four");
  AST_GENERIC: assert property (ce |=> generic_error_ff == $past(any_flt))
    else $error("generic bit not following faults");
  AST_RDATA_HOLD: assert property (!(ce && od_rd) |=> $stable(od_rdata_ff))
    else $error("read data changed without read");
endmodule : deh_error_bank_chk

bind deh_error_bank deh_error_bank_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .in1_over_high(in1_over_high),
  .in1_over_low(in1_over_low), .out_open(out_open), .out_short(out_short),
  .rpdo_timeout(rpdo_timeout), .lifeguard_event(lifeguard_event), .hb_timeout(hb_timeout),
  .od_rd(od_rd), .od_wr(od_wr), .od_index(od_index), .od_subindex(od_subindex),
  .od_rdata_ff(od_rdata_ff), .od_ack_ff(od_ack_ff), .od_abort_ff(od_abort_ff),
  .generic_error_ff(generic_error_ff)
);

`default_nettype wire

// >>> deh_can_master.sv
/*
  Network-master model: issues dictionary accesses and notes expected answers.
  Assumes each access is answered one clock after it is taken.
*/
`default_nettype none

module deh_can_master (
  input  wire logic        clk_sys,
  output logic             od_rd,
  output logic             od_wr,
  output logic      [15:0] od_index,
  output logic      [7:0]  od_subindex,
  output logic      [31:0] od_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic ab; logic chk; logic [31:0] d;} deh_exp_t;
  deh_exp_t expq[$];

  initial begin
    od_rd = 1'b0;
    od_wr = 1'b0;
    od_index = 16'h0000;
    od_subindex = 8'h00;
    od_wdata = 32'h00000000;
  end

  // Strobe stays up until the next call or idle(); a following call makes the accesses back to back
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, input logic ab, input logic chk,
                      input logic [31:0] d);
    @(negedge clk_sys);
    od_rd <= !wr;
    od_wr <= wr;
    od_index <= idx;
    od_subindex <= sub;
    od_wdata <= wd;
    expq.push_back('{ab, chk, d});
  endtask : xfer

  // Released lines are inverted so a stale value cannot pass for a live one
  task automatic idle();
    @(negedge clk_sys);
    od_rd <= 1'b0;
    od_wr <= 1'b0;
    od_index <= ~od_index;
    od_subindex <= ~od_subindex;
    od_wdata <= ~od_wdata;
  endtask : idle
endmodule : deh_can_master

`default_nettype wire

// >>> device_error_history_tb.sv
/*
  Self-checking bench of deh_error_bank driven by the network-master model.
  Assumes the header, package, interface, design files and checker come first.
*/
`default_nettype none
`include "deh_cfg.svh"

module device_error_history_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [8:0]  flt = 9'h000;
  logic [7:0]  hb_id = 8'h00;
  logic        od_rd, od_wr, od_ack_ff, od_abort_ff, generic_error_ff;
  logic [15:0] od_index;
  logic [7:0]  od_subindex;
  logic [31:0] od_wdata, od_rdata_ff;
  int          seed = 80;
  int          failures = 0;
  int          checks = 0;
  int          ord [5] = '{0, 2, 4, 6, 7};
  logic [31:0] code [9] = '{32'h2001F001, 32'h4001F001, 32'h1001F002, 32'h1002F002,
                            32'h00012310, 32'h00022310, 32'h00008100, 32'h10008130, 32'h0};

  deh_error_bank dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .in1_over_high(flt[0]), .in1_over_low(flt[1]),
    .out_open(flt[3:2]), .out_short(flt[5:4]), .rpdo_timeout(flt[6]),
    .lifeguard_event(flt[7]), .hb_timeout(flt[8]), .hb_node_id(hb_id), .od_rd(od_rd),
    .od_wr(od_wr), .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata),
    .od_rdata_ff(od_rdata_ff), .od_ack_ff(od_ack_ff), .od_abort_ff(od_abort_ff),
    .generic_error_ff(generic_error_ff)
  );
  deh_can_master mst (.clk_sys(clk_sys), .od_rd(od_rd), .od_wr(od_wr), .od_index(od_index),
    .od_subindex(od_subindex), .od_wdata(od_wdata));

  always #20 clk_sys = ~clk_sys;

  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_word

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    cmp_word(nm, {31'h0, e}, {31'h0, g});
  endtask : cmp_bit

  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    mst.xfer(1'b0, i, s, 32'h0, 1'b0, 1'b1, d);
  endtask : rd

  task automatic bad(input logic w, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] wd);
    mst.xfer(w, i, s, wd, 1'b1, 1'b0, 32'h0);
  endtask : bad

  task automatic setf(input int s, input logic v);
    mst.idle();
    flt[s] = v;
    @(negedge clk_sys);
    cmp_bit("generic", |flt, generic_error_ff);
  endtask : setf

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  always @(negedge clk_sys) begin
    if (od_ack_ff === 1'b1) begin
      if (mst.expq.size() == 0) begin
        cmp_bit("ack", 1'b0, od_ack_ff);
      end else begin
        cmp_bit("abort", mst.expq[0].ab, od_abort_ff);
        if (mst.expq[0].chk) cmp_word("rdata", mst.expq[0].d, od_rdata_ff);
        void'(mst.expq.pop_front());
      end
    end
  end

  // The tests need well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(16'h1000, 8'h00, {`DEH_FB_ANA_IN | `DEH_FB_ANA_OUT, 16'h0001});
    rd(16'h1001, 8'h00, 32'h0);
    rd(16'h1003, 8'h00, 32'h0);
    for (int i = 1; i <= 4; i++) rd(16'h1003, 8'(i), 32'h0);
    bad(1'b0, 16'h1004, 8'h00, 32'h0);
    bad(1'b0, 16'h1003, 8'h05, 32'h0);
    bad(1'b1, 16'h1003, 8'h01, 32'h0);
    bad(1'b1, 16'h1003, 8'h00, 32'h1);
    bad(1'b1, 16'h1001, 8'h00, 32'h0);
    for (int s = 0; s < 9; s++) begin
      hb_id = 8'($random(seed));
      code[8] = {8'h80, hb_id, 16'h8130};
      setf(s, 1'b1);
      rd(16'h1003, 8'h00, 32'h1);
      rd(16'h1003, 8'h01, code[s]);
      setf(s, 1'b0);
      rd(16'h1003, 8'h00, 32'h0);
      rd(16'h1003, 8'h01, 32'h0);
    end
    foreach (ord[k]) setf(ord[k], 1'b1);
    rd(16'h1003, 8'h00, 32'h4);
    rd(16'h1003, 8'h01, code[7]);
    rd(16'h1003, 8'h04, code[2]);
    rd(16'h1002, 8'h00, {20'h00000, 3'h4, flt});
    setf(4, 1'b0);
    rd(16'h1003, 8'h00, 32'h3);
    rd(16'h1003, 8'h02, code[6]);
    rd(16'h1003, 8'h03, code[2]);
    setf(0, 1'b0);
    rd(16'h1003, 8'h00, 32'h3);
    mst.xfer(1'b1, 16'h1003, 8'h00, 32'h0, 1'b0, 1'b0, 32'h0);
    rd(16'h1003, 8'h00, 32'h0);
    rd(16'h1001, 8'h00, 32'h1);
    mst.idle();
    // Let the last ack drop first; frozen, it would look like a stray answer
    @(negedge clk_sys);
    ce = 1'b0;
    flt = 9'h000;
    @(negedge clk_sys);
    cmp_bit("generic", 1'b1, generic_error_ff);
    ce = 1'b1;
    @(negedge clk_sys);
    cmp_bit("generic", 1'b0, generic_error_ff);
    rd(16'h1001, 8'h00, 32'h0);
    mst.idle();
    repeat (2) @(negedge clk_sys);
    cmp_word("pending", 32'h0, 32'(mst.expq.size()));
    report_and_stop();
  end
endmodule : device_error_history_tb

`default_nettype wire
